//--- core/aprs_regs.v
// Audio port routing and status register bank: secondary port pin routing,
// serial input source select, clock output routing, general-call enable,
// power and gain status, sticky overflow flags.
// Assumes the control-bus slave hands over one-cycle read and write strobes
// with a 7-bit register address on i_mclk; status arrives from other domains
// and is synchronised here; audio clocks and data pass through unsampled.
//
// Contract
// - Bits 7:5 choose secondary bit clock source: 000 from pin, 001 not.
// - Bits 4:2 choose secondary word clock source: 000 from pin, 001 not.
// - Bits 1:0 choose secondary data input source: 00 from pin, 01 not.
// - Bit 3 picks primary or secondary bit clock for interface and clock generator.
// - Bit 2 picks primary or secondary word clock for serial interface.
// - Bit 0 picks primary or secondary data input for serial interface.
// - Primary bit clock output: internal when bit 7 clear, secondary when set.
// - Secondary bit clock output: primary when bit 6 clear, internal when set.
// - Bits 5:4 primary word clock out: 00 sample clock, 10 secondary.
// - Bits 3:2 secondary word clock out: 00 primary, 01 sample clock.
// - Bus condition bit 5 enables acceptance of the general-call address.
// - Read-only power status for converters, headphone and speaker drivers.
// - Gain-settled bits 4 and 0 read 1 when applied equals programmed gain.
// - Overflow register bits 7,6,5 report overflows; bits 4:0 read zero.
// - Overflow flags are sticky, clear on read, set again on recurrence.
// - All routing fields reset to zero: primary sources, internal clocks out.
`timescale 1ns/1ps
`default_nettype none
`include "aprs_defs.vh"

module aprs_regs (
  input wire i_mclk,
  input wire i_arst_n,
  // Register access from the control-bus slave
  input wire i_reg_wr,
  input wire i_reg_rd,
  input wire [6:0] i_reg_addr,
  input wire [7:0] i_reg_wdata,
  output wire [7:0] o_reg_rdata,
  // Audio clocks and data at the pins and inside
  input wire i_multi_function_pin_one,
  input wire i_pri_bclk,
  input wire i_pri_wclk,
  input wire i_pri_din,
  input wire i_alt_sec_bclk,
  input wire i_alt_sec_wclk,
  input wire i_alt_sec_din,
  input wire i_int_bclk,
  input wire i_converter_sample_rate_clock,
  output wire o_if_bclk,
  output wire o_if_wclk,
  output wire o_if_din,
  output wire o_clock_generator_block_bclk,
  output wire o_pri_bclk_out,
  output wire o_sec_bclk_out,
  output wire o_pri_wclk_out,
  output wire o_sec_wclk_out,
  // Bus condition
  output wire o_gcall_accept,
  // Status from the analog and gain blocks
  input wire [5:0] i_power_up,
  input wire [1:0] i_gain_settled,
  input wire [2:0] i_ovf_event
);

  // ------------------------------------------------------------
  // Reset release
  // ------------------------------------------------------------
  reg rst_meta_r;
  reg rst_r;

  // Asynchronous assert, two-stage synchronous release
  // Release lags the pin by two edges, so no access is taken before the third
  always @(posedge i_mclk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      rst_meta_r <= 1'b0;
      rst_r <= 1'b0;
    end else begin
      rst_meta_r <= 1'b1;
      rst_r <= rst_meta_r;
    end
  end

  // ------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------
  // Address compare used by every write decode and by the overflow read strobe
  function hit;
    input [6:0] addr;
    input [6:0] ofs;
    begin
      hit = (addr == ofs);
    end
  endfunction

  // Two-way clock/data mux
  function pick;
    input sel;
    input a;
    input b;
    begin
      pick = sel ? b : a;
    end
  endfunction

  // ------------------------------------------------------------
  // Writable registers
  // ------------------------------------------------------------
  reg [7:0] pin_sel_r;
  reg [7:0] src_sel_r;
  reg [7:0] clk_out_r;
  reg [7:0] gcall_r;
  reg [7:0] pin_sel_nxt;
  reg [7:0] src_sel_nxt;
  reg [7:0] clk_out_nxt;
  reg [7:0] gcall_nxt;

  // Next values: a write strobe at a matching offset replaces the byte
  always @* begin
    pin_sel_nxt = pin_sel_r;
    src_sel_nxt = src_sel_r;
    clk_out_nxt = clk_out_r;
    gcall_nxt = gcall_r;
    if (i_reg_wr) begin
      if (hit(i_reg_addr, `APRS_OFS_PIN_SEL)) begin
        pin_sel_nxt = i_reg_wdata;
      end
      if (hit(i_reg_addr, `APRS_OFS_SRC_SEL)) begin
        src_sel_nxt = i_reg_wdata;
      end
      if (hit(i_reg_addr, `APRS_OFS_CLK_OUT)) begin
        clk_out_nxt = i_reg_wdata;
      end
      // Reserved bits stored as written; software keeps them at reset
      if (hit(i_reg_addr, `APRS_OFS_GCALL)) begin
        gcall_nxt = i_reg_wdata;
      end
    end
  end

  // Every routing field starts at zero: primary in, internal out
  // Flops load every edge; holding is done by the next-value logic
  always @(posedge i_mclk or negedge rst_r) begin
    if (!rst_r) begin
      pin_sel_r <= `APRS_RST_BYTE;
      src_sel_r <= `APRS_RST_BYTE;
      clk_out_r <= `APRS_RST_BYTE;
      gcall_r <= `APRS_RST_BYTE;
    end else begin
      pin_sel_r <= pin_sel_nxt;
      src_sel_r <= src_sel_nxt;
      clk_out_r <= clk_out_nxt;
      gcall_r <= gcall_nxt;
    end
  end

  assign o_gcall_accept = gcall_r[`APRS_GCALL_BIT];

  // ------------------------------------------------------------
  // Secondary port pin routing
  // ------------------------------------------------------------
  // Only code zero routes the pin; 001 and reserved codes use the alternate
  wire sec_bclk_from_pin;
  wire sec_wclk_from_pin;
  wire sec_din_from_pin;
  wire sec_bclk;
  wire sec_wclk;
  wire sec_din;

  assign sec_bclk_from_pin = (pin_sel_r[`APRS_PIN_BCLK_HI:`APRS_PIN_BCLK_LO] == `APRS_PIN3_FROM_PIN);
  assign sec_wclk_from_pin = (pin_sel_r[`APRS_PIN_WCLK_HI:`APRS_PIN_WCLK_LO] == `APRS_PIN3_FROM_PIN);
  assign sec_din_from_pin = (pin_sel_r[`APRS_PIN_DIN_HI:`APRS_PIN_DIN_LO] == `APRS_PIN2_FROM_PIN);
  assign sec_bclk = pick(sec_bclk_from_pin, i_alt_sec_bclk, i_multi_function_pin_one);
  assign sec_wclk = pick(sec_wclk_from_pin, i_alt_sec_wclk, i_multi_function_pin_one);
  assign sec_din = pick(sec_din_from_pin, i_alt_sec_din, i_multi_function_pin_one);

  // ------------------------------------------------------------
  // Serial interface source selection
  // ------------------------------------------------------------
  // Audio clocks pass combinationally; they are not sampled by i_mclk
  assign o_if_bclk = pick(src_sel_r[`APRS_SRC_BCLK], i_pri_bclk, sec_bclk);
  assign o_clock_generator_block_bclk = pick(src_sel_r[`APRS_SRC_BCLK], i_pri_bclk, sec_bclk);
  assign o_if_wclk = pick(src_sel_r[`APRS_SRC_WCLK], i_pri_wclk, sec_wclk);
  assign o_if_din = pick(src_sel_r[`APRS_SRC_DIN], i_pri_din, sec_din);

  // ------------------------------------------------------------
  // Clock output routing
  // ------------------------------------------------------------
  wire [1:0] pwclk_code;
  wire [1:0] swclk_code;
  reg pri_wclk_out;
  reg sec_wclk_out;

  assign o_pri_bclk_out = pick(clk_out_r[`APRS_OUT_PBCLK], i_int_bclk, sec_bclk);
  assign o_sec_bclk_out = pick(clk_out_r[`APRS_OUT_SBCLK], o_pri_bclk_out, i_int_bclk);
  assign pwclk_code = clk_out_r[`APRS_OUT_PWCLK_HI:`APRS_OUT_PWCLK_LO];
  assign swclk_code = clk_out_r[`APRS_OUT_SWCLK_HI:`APRS_OUT_SWCLK_LO];

  // Reserved codes fall back to the reset choice so the pin never floats
  always @* begin
    case (pwclk_code)
      `APRS_PWCLK_SEC: pri_wclk_out = sec_wclk;
      default: pri_wclk_out = i_converter_sample_rate_clock;
    endcase
  end

  always @* begin
    case (swclk_code)
      `APRS_SWCLK_INT: sec_wclk_out = i_converter_sample_rate_clock;
      default: sec_wclk_out = pri_wclk_out;
    endcase
  end

  assign o_pri_wclk_out = pri_wclk_out;
  assign o_sec_wclk_out = sec_wclk_out;

  // ------------------------------------------------------------
  // Status inputs, synchronised
  // ------------------------------------------------------------
  // Power and gain states come from slower analog domains
  // Overflow levels share the same stages, so a flag lags its source
  wire [5:0] pwr_s;
  wire [1:0] gain_s;
  wire [2:0] ovf_s;
  wire [10:0] stat_in;
  wire [10:0] stat_s;

  assign stat_in = {i_ovf_event, i_gain_settled, i_power_up};

  genvar gi;
  generate
    for (gi = 0; gi < 11; gi = gi + 1) begin : g_sync
      aprs_sync2 u_sync (
        .i_mclk(i_mclk),
        .i_rst_n(rst_r),
        .i_d(stat_in[gi]),
        .o_q(stat_s[gi])
      );
    end
  endgenerate

  assign pwr_s = stat_s[5:0];
  assign gain_s = stat_s[7:6];
  assign ovf_s = stat_s[10:8];

  // ------------------------------------------------------------
  // Sticky overflow flags
  // ------------------------------------------------------------
  wire ovf_rd;
  wire [2:0] ovf_flags;
  reg [2:0] ovf_d_r;
  wire [2:0] ovf_rise;

  assign ovf_rd = i_reg_rd & hit(i_reg_addr, `APRS_OFS_OVF);

  // Edge detect so a held overflow level does not re-set after the read
  always @(posedge i_mclk or negedge rst_r) begin
    if (!rst_r) begin
      ovf_d_r <= 3'h0;
    end else begin
      ovf_d_r <= ovf_s;
    end
  end

  assign ovf_rise = ovf_s & ~ovf_d_r;

  aprs_ovf_flags u_ovf (
    .i_mclk(i_mclk),
    .i_rst_n(rst_r),
    .i_event(ovf_rise),
    .i_clear(ovf_rd),
    .o_flags(ovf_flags)
  );

  // ------------------------------------------------------------
  // Read data
  // ------------------------------------------------------------
  reg [7:0] rdata_r;
  reg [7:0] rdata_nxt;

  // Reserved and unmapped locations read zero; status uses synchronised copies
  // Without a read strobe the byte holds, so the flops need no load enable
  always @* begin
    rdata_nxt = rdata_r;
    if (i_reg_rd) begin
      case (i_reg_addr)
        `APRS_OFS_PIN_SEL: rdata_nxt = pin_sel_r;
        `APRS_OFS_SRC_SEL: rdata_nxt = src_sel_r;
        `APRS_OFS_CLK_OUT: rdata_nxt = clk_out_r;
        `APRS_OFS_GCALL: rdata_nxt = gcall_r;
        `APRS_OFS_PWR: rdata_nxt = {pwr_s[5], 1'b0, pwr_s[4:2], 1'b0, pwr_s[1:0]};
        `APRS_OFS_GAIN: rdata_nxt = {3'h0, gain_s[1], 3'h0, gain_s[0]};
        `APRS_OFS_OVF: rdata_nxt = {ovf_flags, 5'h00};
        default: rdata_nxt = 8'h00;
      endcase
    end
  end

  // Data captured on the read strobe, held until the next read
  always @(posedge i_mclk or negedge rst_r) begin
    if (!rst_r) begin
      rdata_r <= 8'h00;
    end else begin
      rdata_r <= rdata_nxt;
    end
  end

  assign o_reg_rdata = rdata_r;

endmodule // aprs_regs

`default_nettype wire

//--- core/aprs_defs.vh
// Register offsets, field positions and reset values of the audio port routing and status bank.
// Included by the aprs_regs module of the bank; definitions only.
`ifndef APRS_DEFS_VH
`define APRS_DEFS_VH

// ------------------------------------------------------------
// Register offsets (7-bit register address space)
// ------------------------------------------------------------
`define APRS_OFS_PIN_SEL 7'h1f
`define APRS_OFS_SRC_SEL 7'h20
`define APRS_OFS_CLK_OUT 7'h21
`define APRS_OFS_GCALL 7'h22
`define APRS_OFS_RSVD_A 7'h23
`define APRS_OFS_RSVD_B 7'h24
`define APRS_OFS_PWR 7'h25
`define APRS_OFS_GAIN 7'h26
`define APRS_OFS_OVF 7'h27
`define APRS_OFS_RSVD_LO 7'h28
`define APRS_OFS_RSVD_HI 7'h2b

// ------------------------------------------------------------
// Reset values
// ------------------------------------------------------------
`define APRS_RST_BYTE 8'h00

// ------------------------------------------------------------
// Field positions
// ------------------------------------------------------------
`define APRS_PIN_BCLK_HI 7
`define APRS_PIN_BCLK_LO 5
`define APRS_PIN_WCLK_HI 4
`define APRS_PIN_WCLK_LO 2
`define APRS_PIN_DIN_HI 1
`define APRS_PIN_DIN_LO 0
`define APRS_SRC_BCLK 3
`define APRS_SRC_WCLK 2
`define APRS_SRC_DIN 0
`define APRS_OUT_PBCLK 7
`define APRS_OUT_SBCLK 6
`define APRS_OUT_PWCLK_HI 5
`define APRS_OUT_PWCLK_LO 4
`define APRS_OUT_SWCLK_HI 3
`define APRS_OUT_SWCLK_LO 2
`define APRS_GCALL_BIT 5
`define APRS_OVF_LEFT 7
`define APRS_OVF_RIGHT 6
`define APRS_OVF_SHIFT 5

// ------------------------------------------------------------
// Field codes
// ------------------------------------------------------------
`define APRS_PIN3_FROM_PIN 3'h0
`define APRS_PIN2_FROM_PIN 2'h0
`define APRS_PWCLK_INT 2'h0
`define APRS_PWCLK_SEC 2'h2
`define APRS_SWCLK_PRI 2'h0
`define APRS_SWCLK_INT 2'h1

`endif

//--- core/aprs_sync2.v
// Two-flip-flop synchroniser for a single level from outside the clock domain.
// Assumes the reset given is already synchronous to i_mclk on release.
`timescale 1ns/1ps
`default_nettype none

module aprs_sync2 (
  input wire i_mclk,
  input wire i_rst_n,
  input wire i_d,
  output wire o_q
);
  reg meta_r;
  reg sync_r;

  // First stage is read only by the second stage
  always @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      meta_r <= 1'b0;
      sync_r <= 1'b0;
    end else begin
      meta_r <= i_d;
      sync_r <= meta_r;
    end
  end

  assign o_q = sync_r;
endmodule // aprs_sync2

`default_nettype wire

//--- core/aprs_ovf_flags.v
// Sticky overflow flags that clear when their register is read.
// Assumes event inputs are single-cycle or level pulses on i_mclk.
`timescale 1ns/1ps
`default_nettype none

module aprs_ovf_flags (
  input wire i_mclk,
  input wire i_rst_n,
  input wire [2:0] i_event,
  input wire i_clear,
  output wire [2:0] o_flags
);
  reg [2:0] flags_r;
  wire [2:0] flags_nxt;

  // Set wins over read-clear so an event is never lost
  assign flags_nxt = (i_clear ? 3'h0 : flags_r) | i_event;

  always @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      flags_r <= 3'h0;
    end else begin
      flags_r <= flags_nxt;
    end
  end

  assign o_flags = flags_r;
endmodule // aprs_ovf_flags

`default_nettype wire

//--- verification/aprs_regs_chk.sv
// Checker for the routing and status bank: muxes, general call, read data.
// Assumes it is bound to aprs_regs and sees only that module's ports.
`timescale 1ns/1ps
`default_nettype none

module aprs_regs_chk (
  input wire logic i_mclk,
  input wire logic i_arst_n,
  input wire logic i_reg_wr,
  input wire logic i_reg_rd,
  input wire logic [6:0] i_reg_addr,
  input wire logic [7:0] i_reg_wdata,
  input wire logic [7:0] o_reg_rdata,
  input wire logic i_multi_function_pin_one,
  input wire logic i_pri_bclk,
  input wire logic i_pri_wclk,
  input wire logic i_pri_din,
  input wire logic i_alt_sec_bclk,
  input wire logic i_alt_sec_wclk,
  input wire logic i_alt_sec_din,
  input wire logic i_int_bclk,
  input wire logic i_converter_sample_rate_clock,
  input wire logic o_if_bclk,
  input wire logic o_if_wclk,
  input wire logic o_if_din,
  input wire logic o_clock_generator_block_bclk,
  input wire logic o_pri_bclk_out,
  input wire logic o_sec_bclk_out,
  input wire logic o_pri_wclk_out,
  input wire logic o_sec_wclk_out,
  input wire logic o_gcall_accept
);
  // ------------------------------------------------------------
  // Shadow of the writable bytes
  // ------------------------------------------------------------
  logic [7:0] pin_r, src_r, out_r, gc_r;
  logic sb, sw, sd;

  // Follows every write so the muxes can be judged at any time
  always_ff @(posedge i_mclk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      pin_r <= 8'h00;
      src_r <= 8'h00;
      out_r <= 8'h00;
      gc_r <= 8'h00;
    end else if (i_reg_wr) begin
      if (i_reg_addr == 7'h1f) pin_r <= i_reg_wdata;
      if (i_reg_addr == 7'h20) src_r <= i_reg_wdata;
      if (i_reg_addr == 7'h21) out_r <= i_reg_wdata;
      if (i_reg_addr == 7'h22) gc_r <= i_reg_wdata;
    end
  end

  // Reserved codes count as not from the pin
  assign sb = (pin_r[7:5] == 3'h0) ? i_multi_function_pin_one : i_alt_sec_bclk;
  assign sw = (pin_r[4:2] == 3'h0) ? i_multi_function_pin_one : i_alt_sec_wclk;
  assign sd = (pin_r[1:0] == 2'h0) ? i_multi_function_pin_one : i_alt_sec_din;

  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_arst_n);

  // ------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------
  a_bclk_gen_route: assert property (o_clock_generator_block_bclk == (src_r[3] ? sb : i_pri_bclk))
    else $error("clock generator bit clock misrouted");
  a_bclk_if_twin: assert property (o_if_bclk == o_clock_generator_block_bclk)
    else $error("interface bit clock differs");
  a_wclk_if_route: assert property (o_if_wclk == (src_r[2] ? sw : i_pri_wclk))
    else $error("interface word clock misrouted");
  a_din_if_route: assert property (o_if_din == (src_r[0] ? sd : i_pri_din))
    else $error("interface data misrouted");
  a_pbclk_out_sel: assert property (o_pri_bclk_out == (out_r[7] ? sb : i_int_bclk))
    else $error("primary bit clock output wrong");
  a_sbclk_out_sel: assert property (o_sec_bclk_out == (out_r[6] ? i_int_bclk : o_pri_bclk_out))
    else $error("secondary bit clock output wrong");
  a_pwclk_out_sel: assert property
    (o_pri_wclk_out == ((out_r[5:4] == 2'h2) ? sw : i_converter_sample_rate_clock))
    else $error("primary word clock output wrong");
  a_swclk_out_sel: assert property
    (o_sec_wclk_out == ((out_r[3:2] == 2'h1) ? i_converter_sample_rate_clock : o_pri_wclk_out))
    else $error("secondary word clock output wrong");
  a_gcall_after_wr: assert property
    (i_reg_wr && i_reg_addr == 7'h22 |=> o_gcall_accept == $past(i_reg_wdata[5]))
    else $error("general call level wrong");
  a_ovf_low_zero: assert property (i_reg_rd && i_reg_addr == 7'h27 |=> o_reg_rdata[4:0] == 5'h00)
    else $error("overflow low bits not zero");
  a_rdata_holds: assert property (!i_reg_rd |=> $stable(o_reg_rdata))
    else $error("read data changed without a read");

  // Main scenarios reached
  c_sec_from_pin: cover property (src_r[3] && pin_r[7:5] == 3'h0);
  c_gcall_on: cover property (o_gcall_accept);
  c_ovf_seen: cover property (i_reg_rd && i_reg_addr == 7'h27 ##1 o_reg_rdata[7:5] != 3'h0);
endmodule // aprs_regs_chk

`default_nettype wire

//--- verification/aprs_host.sv
// Host processor model: one-cycle read and write strobes to the bank.
// Assumes the bench calls xfer; every change lands on a falling edge.
`timescale 1ns/1ps
`default_nettype none

module aprs_host (
  input wire logic i_mclk,
  input wire logic [7:0] i_rdata,
  output var logic o_wr,
  output var logic o_rd,
  output var logic [6:0] o_addr,
  output var logic [7:0] o_wdata
);
  // Idle bus at time zero
  initial begin
    o_wr = 1'b0;
    o_rd = 1'b0;
    o_addr = 7'h00;
    o_wdata = 8'h00;
  end

  // One access; read data taken a cycle after the strobe edge
  task automatic xfer(input logic w, input logic [6:0] a, input logic [7:0] d, output logic [7:0] q);
    q = 8'h00;
    // Only the reserved slots are skipped; status bytes in between stay reachable
    if (a != 7'h23 && a != 7'h24 && (a < 7'h28 || a > 7'h2b)) begin
      @(negedge i_mclk);
      o_wr = w;
      o_rd = !w;
      o_addr = a;
      o_wdata = (a == 7'h22) ? (d & 8'h20) : d;
      @(negedge i_mclk);
      q = i_rdata;
      o_wr = 1'b0;
      o_rd = 1'b0;
      o_addr = ~a; // Released lines never keep the old value
      o_wdata = ~o_wdata;
    end
  endtask
endmodule // aprs_host

`default_nettype wire

//--- verification/test_aprs_regs.sv
// Testbench for aprs_regs: random routing, status and sticky flags.
// Assumes the host model in aprs_host and the checker in aprs_regs_chk.
`timescale 1ns/1ps
`default_nettype none

module test_aprs_regs;
  logic i_mclk, i_arst_n, i_reg_wr, i_reg_rd;
  logic [6:0] i_reg_addr, a;
  logic [7:0] i_reg_wdata, o_reg_rdata, q, q1, d, route;
  logic [7:0] sh [4];
  logic [7:0] cb [8] = '{8'h00, 8'h0d, 8'ha4, 8'h20, 8'h25, 8'h0d, 8'h48, 8'h00};
  logic i_multi_function_pin_one, i_pri_bclk, i_pri_wclk, i_pri_din, i_alt_sec_bclk;
  logic i_alt_sec_wclk, i_alt_sec_din, i_int_bclk, i_converter_sample_rate_clock;
  logic o_if_bclk, o_if_wclk, o_if_din, o_clock_generator_block_bclk, o_pri_bclk_out;
  logic o_sec_bclk_out, o_pri_wclk_out, o_sec_wclk_out, o_gcall_accept;
  logic [5:0] i_power_up;
  logic [1:0] i_gain_settled;
  logic [2:0] i_ovf_event, e;
  int n_errors = 0;
  int compares = 0;

  aprs_regs DUT (.i_mclk, .i_arst_n, .i_reg_wr, .i_reg_rd, .i_reg_addr, .i_reg_wdata, .o_reg_rdata,
    .i_multi_function_pin_one, .i_pri_bclk, .i_pri_wclk, .i_pri_din, .i_alt_sec_bclk, .i_alt_sec_wclk,
    .i_alt_sec_din, .i_int_bclk, .i_converter_sample_rate_clock, .o_if_bclk, .o_if_wclk, .o_if_din,
    .o_clock_generator_block_bclk, .o_pri_bclk_out, .o_sec_bclk_out, .o_pri_wclk_out, .o_sec_wclk_out,
    .o_gcall_accept, .i_power_up, .i_gain_settled, .i_ovf_event);
  aprs_host u_host (.i_mclk, .i_rdata(o_reg_rdata), .o_wr(i_reg_wr), .o_rd(i_reg_rd), .o_addr(i_reg_addr),
    .o_wdata(i_reg_wdata));

  assign route = {o_if_bclk, o_clock_generator_block_bclk, o_if_wclk, o_if_din, o_pri_bclk_out,
    o_sec_bclk_out, o_pri_wclk_out, o_sec_wclk_out};

  // ------------------------------------------------------------
  // Clock, audio stimulus, helpers
  // ------------------------------------------------------------
  initial begin
    i_mclk = 1'b0;
    forever #20 i_mclk = ~i_mclk;
  end

  // Audio lines toggle at random on every falling edge
  always @(negedge i_mclk) begin
    {i_multi_function_pin_one, i_pri_bclk, i_pri_wclk, i_pri_din, i_alt_sec_bclk, i_alt_sec_wclk,
      i_alt_sec_din, i_int_bclk, i_converter_sample_rate_clock} <= 9'($urandom);
  end

  // Expected mux outputs from the shadow bytes and the live inputs
  function automatic logic [7:0] exp_route();
    logic sb, sw, sd, bc, pb, pw;
    sb = (sh[0][7:5] == 3'h0) ? i_multi_function_pin_one : i_alt_sec_bclk;
    sw = (sh[0][4:2] == 3'h0) ? i_multi_function_pin_one : i_alt_sec_wclk;
    sd = (sh[0][1:0] == 2'h0) ? i_multi_function_pin_one : i_alt_sec_din;
    bc = sh[1][3] ? sb : i_pri_bclk;
    pb = sh[2][7] ? sb : i_int_bclk;
    pw = (sh[2][5:4] == 2'h2) ? sw : i_converter_sample_rate_clock;
    return {bc, bc, sh[1][2] ? sw : i_pri_wclk, sh[1][0] ? sd : i_pri_din, pb,
      sh[2][6] ? i_int_bclk : pb, pw, (sh[2][3:2] == 2'h1) ? i_converter_sample_rate_clock : pw};
  endfunction

  task automatic chk(input string n, input logic [7:0] ex, input logic [7:0] g);
    compares++;
    if (g !== ex) begin
      n_errors++;
      $display("unexpected %s: expected %h seen %h", n, ex, g);
    end
  endtask

  task automatic report_and_stop();
    $display("errors %0d compares %0d", n_errors, compares);
    if (n_errors == 0 && compares > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  // Reset pulse, then every routing byte must read zero and the outputs follow the reset routing
  task automatic reset_and_check(input int n);
    @(negedge i_mclk);
    i_arst_n = 1'b0;
    sh = '{8'h00, 8'h00, 8'h00, 8'h00};
    repeat (n) @(negedge i_mclk);
    i_arst_n = 1'b1;
    repeat (3) @(negedge i_mclk);
    for (int i = 0; i < 4; i++) begin
      u_host.xfer(1'b0, 7'h1f + 7'(i), 8'h00, q);
      chk("reset byte", 8'h00, q);
    end
    @(posedge i_mclk);
    #1 chk("reset routing", exp_route(), route);
  endtask

  // Hang guard: 50000 cycles at most
  initial begin
    #2000000;
    n_errors++;
    $display("unexpected timeout");
    report_and_stop();
  end

  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial begin
    q = 8'($urandom(32'h59bce16a));
    i_arst_n = 1'b0;
    {i_power_up, i_gain_settled, i_ovf_event} = 11'h000;
    reset_and_check(16);
    // Corner table first, then random bytes
    for (int i = 0; i < 48; i++) begin
      a = (i < 8) ? 7'h1f + 7'(i % 4) : 7'h1f + 7'($urandom_range(3));
      d = (i < 8) ? cb[i] : 8'($urandom);
      if (a == 7'h22) d = d & 8'h20;
      u_host.xfer(1'b1, a, d, q);
      sh[a - 7'h1f] = d;
      u_host.xfer(1'b0, a, 8'h00, q);
      chk("config byte", d, q);
      repeat (4) begin
        @(posedge i_mclk);
        #1 chk("routed clocks", exp_route(), route);
      end
      chk("general call", {7'h00, sh[3][5]}, {7'h00, o_gcall_accept});
    end
    // Mid-run reset drops the random settings back to zero
    reset_and_check(4);
    chk("general call reset", 8'h00, {7'h00, o_gcall_accept});
    // Unmapped and read-only places ignore writes
    u_host.xfer(1'b1, 7'h10, 8'hff, q);
    u_host.xfer(1'b0, 7'h10, 8'h00, q);
    chk("unmapped byte", 8'h00, q);
    u_host.xfer(1'b1, 7'h25, 8'hff, q);
    for (int i = 0; i < 6; i++) begin
      {i_power_up, i_gain_settled} = 8'($urandom);
      repeat (4) @(negedge i_mclk);
      u_host.xfer(1'b0, 7'h25, 8'h00, q);
      chk("power flags", {i_power_up[5], 1'b0, i_power_up[4:2], 1'b0, i_power_up[1:0]}, q & 8'hbb);
      u_host.xfer(1'b0, 7'h26, 8'h00, q);
      chk("gain flags", {3'h0, i_gain_settled[1], 3'h0, i_gain_settled[0]}, q & 8'h11);
    end
    // Clearing read swept across the moment the flag sets
    for (int k = 0; k < 8; k++) begin
      e = 3'($urandom_range(7, 1));
      i_ovf_event = e;
      repeat (k) @(negedge i_mclk);
      u_host.xfer(1'b0, 7'h27, 8'h00, q1);
      i_ovf_event = 3'h0;
      repeat (6) @(negedge i_mclk);
      u_host.xfer(1'b0, 7'h27, 8'h00, q);
      chk("overflow kept", {e, 5'h00}, q1 | q);
      chk("overflow once", 8'h00, q1 & q);
      u_host.xfer(1'b0, 7'h27, 8'h00, q);
      chk("overflow cleared", 8'h00, q);
    end
    report_and_stop();
  end
endmodule // test_aprs_regs

bind aprs_regs aprs_regs_chk u_chk (.i_mclk, .i_arst_n, .i_reg_wr, .i_reg_rd, .i_reg_addr, .i_reg_wdata,
  .o_reg_rdata, .i_multi_function_pin_one, .i_pri_bclk, .i_pri_wclk, .i_pri_din, .i_alt_sec_bclk,
  .i_alt_sec_wclk, .i_alt_sec_din, .i_int_bclk, .i_converter_sample_rate_clock, .o_if_bclk, .o_if_wclk,
  .o_if_din, .o_clock_generator_block_bclk, .o_pri_bclk_out, .o_sec_bclk_out, .o_pri_wclk_out,
  .o_sec_wclk_out, .o_gcall_accept);

`default_nettype wire
